// ==== wdt_pkg.sv ====
// package: register map, field layout and timing constants of the watchdog
package wdt_pkg;
   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned PRE_W      = 12;
   localparam int unsigned CNT_W      = 6;
   localparam int unsigned EV_N       = 2;
   // register word indices; the clear location is the top of the map
   localparam logic [15:0] IDX_CTRL   = 16'h0000;
   localparam logic [15:0] IDX_RSTAT  = 16'h0001;
   localparam logic [15:0] IDX_ISTAT  = 16'h0002;
   localparam logic [15:0] IDX_IEN    = 16'h0003;
   localparam logic [15:0] IDX_ICLR   = 16'h0004;
   localparam logic [15:0] IDX_STATE  = 16'h0005;
   localparam logic [15:0] IDX_CLEAR  = 16'hffff;
   // field positions
   localparam int unsigned CTRL_DIS   = 0;
   localparam int unsigned CTRL_LONG  = 1;
   localparam int unsigned EV_OVF     = 0;
   localparam int unsigned EV_SVC     = 1;
   localparam int unsigned CLR_LO     = 3;
   // reset values
   localparam logic [1:0]  CTRL_RST   = 2'h0;
   localparam logic [1:0]  IEN_RST    = 2'h0;
   // cycle counts on the crystal clock
   localparam int unsigned SHORT_CYC  = (1 << 13) - (1 << 4);
   localparam int unsigned LONG_CYC   = (1 << 18) - (1 << 4);
   localparam int unsigned PIN_LOW    = 32;
   localparam logic [12:0] POR_CYC    = 13'h1000;
   localparam real         CLK_MHZ    = 40.0;

   typedef struct packed {
      logic stopMode;
      logic monitorMode;
      logic breakState;
      logic hiVoltRst;
      logic hiVoltIrq;
   } wdt_mode_t;

   typedef struct packed {
      logic stopExec;
      logic vectorFetch;
      logic internalReset;
   } wdt_evt_t;
endpackage

// ==== wdt_top.sv ====
// watchdog: prescaler and overflow counter, avalon-mm register slave, reset pulse and pin drive
// Behaviour
// - a 6-bit counter advances on each carry of a 12-bit prescaler, both on the crystal clock.
// - without clearing, overflow resets the chip after the short or long cycle count chosen.
// - any write to the clear location zeroes the counter and prescaler stages 4 to 12.
// - a read of the clear location returns the low byte of the reset vector.
// - an overflow pulls the reset pin low for 32 cycles and sets the watchdog reset flag.
// - in monitor mode a high test voltage on the reset or interrupt pin stops watchdog resets.
// - in the break state a high test voltage on the reset pin disables the watchdog.
// - the stop instruction clears the prescaler and stop mode freezes the watchdog.
// - the prescaler is cleared once 4096 cycles after power-up.
// - any internal reset clears both the prescaler and the counter.
// - a reset vector fetch clears the prescaler.
// - the disable bit blocks all resets and the long select bit picks the timeout.
// - besides the reset, the watchdog raises irq for each enabled overflow or clear event.
// - the watchdog keeps counting in wait mode.
// - in monitor mode, removing the test voltage from both the interrupt and the reset pin enables the watchdog.
`timescale 1ns/1ps
`default_nettype none
module wdt_top #(
   parameter int unsigned SHORT_CYCLES = wdt_pkg::SHORT_CYC,
   parameter int unsigned LONG_CYCLES  = wdt_pkg::LONG_CYC,
   parameter logic [7:0]  RESET_VEC_LO = 8'h00 // arbitrary default
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   // avalon-mm slave, word addressed
   input  wire logic [wdt_pkg::ADDR_W-1:0]    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [wdt_pkg::DATA_W-1:0]    avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [wdt_pkg::DATA_W-1:0]    avs_readdata,
   output logic                               avs_waitrequest,
   // core state and events
   input  wire wdt_pkg::wdt_mode_t            mode,
   input  wire wdt_pkg::wdt_evt_t             evt,
   // reset outputs and pin
   output logic                               chipReset,
   output logic                               rstPinOut,
   output logic                               rstPinOe,
   output logic                               wdEnable,
   // event line
   output logic                               irq
);
   localparam int unsigned TOT_W = wdt_pkg::PRE_W + wdt_pkg::CNT_W;
   localparam logic [TOT_W-1:0] SHORT_LAST = TOT_W'(SHORT_CYCLES - 1);
   localparam logic [TOT_W-1:0] LONG_LAST  = TOT_W'(LONG_CYCLES - 1);

   // refuse timeouts that the elapsed count cannot reach
   generate
      if (SHORT_CYCLES < 2 || LONG_CYCLES < 2 || SHORT_CYCLES > (1 << TOT_W) ||
          LONG_CYCLES > (1 << TOT_W)) begin : gBadTimeout
         $error("wdt_top: timeout out of counter range");
      end
   endgenerate

   function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
      hit = (a == idx);
   endfunction

   // registers
   logic [wdt_pkg::PRE_W-1:0] pre_r;
   logic [wdt_pkg::CNT_W-1:0] cnt_r;
   logic [1:0]                ctrl_r;
   logic                      rstFlag_r;
   logic [wdt_pkg::EV_N-1:0]  iStat_r;
   logic [wdt_pkg::EV_N-1:0]  iEn_r;
   logic [12:0]               porCnt_r;
   logic                      porDone_r;
   logic [5:0]                pinCnt_r;
   logic                      wait_r;
   logic [31:0]               rdata_r;
   logic                      chipReset_r;
   logic                      pinOe_r;
   logic                      wdEn_r;
   logic                      irq_r;

   // bus decode
   wire       busReq   = avs_read | avs_write;
   wire       acc      = busReq & ~wait_r;
   wire       wrAcc    = acc & avs_write;
   wire       wrLo     = wrAcc & avs_byteenable[0];
   wire       svcWr    = wrAcc & hit(avs_address, wdt_pkg::IDX_CLEAR);
   wire       ctrlWr   = wrLo & hit(avs_address, wdt_pkg::IDX_CTRL);
   wire       rstatWr  = wrLo & hit(avs_address, wdt_pkg::IDX_RSTAT);
   wire       ienWr    = wrLo & hit(avs_address, wdt_pkg::IDX_IEN);
   wire       iclrWr   = wrLo & hit(avs_address, wdt_pkg::IDX_ICLR);

   // suppression and enable
   wire monHold  = mode.monitorMode & (mode.hiVoltRst | mode.hiVoltIrq);
   wire brkHold  = mode.breakState & mode.hiVoltRst;
   wire enable   = ~ctrl_r[wdt_pkg::CTRL_DIS] & ~monHold & ~brkHold;
   // wait mode is not an input: the counter runs unless stop mode gates it
   wire advance  = ~mode.stopMode;

   // counting
   wire [TOT_W-1:0] elapsed = {cnt_r, pre_r};
   wire [TOT_W-1:0] lastCyc = ctrl_r[wdt_pkg::CTRL_LONG] ? LONG_LAST : SHORT_LAST;
   wire fire     = enable & advance & (elapsed == lastCyc) & ~evt.internalReset & ~svcWr;
   wire clrBoth  = evt.internalReset | chipReset_r;
   wire porClr   = ~porDone_r & (porCnt_r == wdt_pkg::POR_CYC - 13'h1);
   wire clrPre   = evt.stopExec | evt.vectorFetch | porClr;
   wire [wdt_pkg::PRE_W:0] preInc = {1'b0, pre_r} + 13'h1;
   wire preCarry = preInc[wdt_pkg::PRE_W];

   logic [wdt_pkg::PRE_W-1:0] pre_nxt;
   logic [wdt_pkg::CNT_W-1:0] cnt_nxt;
   always_comb begin
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      if (advance) begin
         pre_nxt = preInc[wdt_pkg::PRE_W-1:0];
         cnt_nxt = cnt_r + {5'h0, preCarry};
      end
      if (svcWr) begin
         cnt_nxt = '0;
         pre_nxt[wdt_pkg::PRE_W-1:wdt_pkg::CLR_LO] = '0;
      end
      if (clrPre) begin
         pre_nxt = '0;
      end
      if (clrBoth | fire) begin
         pre_nxt = '0;
         cnt_nxt = '0;
      end
   end

   // interrupt-style event capture; set beats clear
   wire [wdt_pkg::EV_N-1:0] evSet;
   assign evSet[wdt_pkg::EV_OVF] = fire;
   assign evSet[wdt_pkg::EV_SVC] = svcWr;
   logic [wdt_pkg::EV_N-1:0] iStat_nxt;
   genvar g;
   generate
      for (g = 0; g < wdt_pkg::EV_N; g++) begin : gEv
         assign iStat_nxt[g] = evSet[g] | (iStat_r[g] & ~(iclrWr & avs_writedata[g]));
      end
   endgenerate

   // read mux
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0;
      if (hit(avs_address, wdt_pkg::IDX_CTRL))  rmux = {30'h0, ctrl_r};
      if (hit(avs_address, wdt_pkg::IDX_RSTAT)) rmux = {31'h0, rstFlag_r};
      if (hit(avs_address, wdt_pkg::IDX_ISTAT)) rmux = {30'h0, iStat_r};
      if (hit(avs_address, wdt_pkg::IDX_IEN))   rmux = {30'h0, iEn_r};
      if (hit(avs_address, wdt_pkg::IDX_STATE)) rmux = {13'h0, enable, cnt_r, pre_r};
      if (hit(avs_address, wdt_pkg::IDX_CLEAR)) rmux = {24'h0, RESET_VEC_LO};
   end

   // bus handshake: one wait cycle, data registered with the acknowledge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         wait_r  <= ~(busReq & wait_r);
         if (avs_read & wait_r) begin
            rdata_r <= rmux;
         end
      end
   end

   // control and status
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r    <= wdt_pkg::CTRL_RST;
         iEn_r     <= wdt_pkg::IEN_RST;
         iStat_r   <= '0;
         rstFlag_r <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         if (ctrlWr) begin
            ctrl_r <= avs_writedata[1:0];
         end
         if (ienWr) begin
            iEn_r <= avs_writedata[wdt_pkg::EV_N-1:0];
         end
         iStat_r   <= iStat_nxt;
         rstFlag_r <= fire | (rstFlag_r & ~(rstatWr & avs_writedata[0]));
         irq_r     <= |(iStat_nxt & iEn_r);
      end
   end

   // counter, power-up delay, reset pulse and pin
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_r       <= '0;
         cnt_r       <= '0;
         porCnt_r    <= 13'h0;
         porDone_r   <= 1'b0;
         chipReset_r <= 1'b0;
         pinCnt_r    <= 6'h0;
         pinOe_r     <= 1'b0;
         wdEn_r      <= 1'b0;
      end else begin
         pre_r       <= pre_nxt;
         cnt_r       <= cnt_nxt;
         porCnt_r    <= porDone_r ? porCnt_r : porCnt_r + 13'h1;
         porDone_r   <= porDone_r | porClr;
         chipReset_r <= fire;
         wdEn_r      <= enable;
         if (fire) begin
            pinCnt_r <= 6'(wdt_pkg::PIN_LOW - 1);
            pinOe_r  <= 1'b1;
         end else if (pinCnt_r != 6'h0) begin
            pinCnt_r <= pinCnt_r - 6'h1;
         end else begin
            pinOe_r  <= 1'b0;
         end
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;
   assign chipReset       = chipReset_r;
   assign rstPinOut       = 1'b0;
   assign rstPinOe        = pinOe_r;
   assign wdEnable        = wdEn_r;
   assign irq             = irq_r;

   AST_OVF_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
      fire |=> chipReset ##1 !chipReset) else $error("overflow pulse wrong");
   AST_PIN_LOW: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(rstPinOe) |-> ##31 rstPinOe ##1 !rstPinOe) else $error("pin low time wrong");
   AST_FLAG_SET: assert property (@(posedge clk) disable iff (sys_rst)
      fire |=> rstFlag_r) else $error("reset flag not set");
   AST_SVC_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      svcWr |=> cnt_r == 6'h0 && pre_r[11:3] == 9'h0) else $error("service did not clear");
   AST_NO_FIRE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl_r[0] || monHold || brkHold) |=> !chipReset) else $error("reset while disabled");
   AST_STOP_FREEZE: assert property (@(posedge clk) disable iff (sys_rst)
      (mode.stopMode && !svcWr && !clrPre && !clrBoth) |=> $stable(elapsed))
      else $error("counter moved in stop");
   AST_FIRE_AT_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
      (enable && advance && !ctrl_r[1] && elapsed == SHORT_LAST && !svcWr && !evt.internalReset)
      |=> chipReset && elapsed == 18'h0) else $error("short timeout missed");
   AST_INT_RESET: assert property (@(posedge clk) disable iff (sys_rst)
      evt.internalReset |=> elapsed == 18'h0) else $error("internal reset kept count");
   AST_VEC_READ: assert property (@(posedge clk) disable iff (sys_rst)
      (avs_read && wait_r && avs_address == 16'hffff) |=> avs_readdata == {24'h0, RESET_VEC_LO})
      else $error("clear location read wrong");
   AST_BUS_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
      (busReq && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest sequence wrong");

   // prescaler clears and counting
   AST_POR_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      porClr |=> pre_r == 12'h0 && porDone_r)
      else $error("power-up clear missed");
   AST_POR_ONCE: assert property (@(posedge clk) disable iff (sys_rst)
      porDone_r |-> !porClr)
      else $error("power-up clear repeated");
   AST_STOP_EXEC: assert property (@(posedge clk) disable iff (sys_rst)
      evt.stopExec |=> pre_r == 12'h0)
      else $error("stop did not clear prescaler");
   AST_VEC_FETCH: assert property (@(posedge clk) disable iff (sys_rst)
      evt.vectorFetch |=> pre_r == 12'h0)
      else $error("vector fetch did not clear prescaler");
   AST_COUNT_UP: assert property (@(posedge clk) disable iff (sys_rst)
      (advance && !svcWr && !clrPre && !clrBoth && !fire)
      |=> elapsed == $past(elapsed) + 18'h1)
      else $error("count did not advance");
   AST_LONG_AT_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
      (enable && advance && ctrl_r[1] && elapsed == LONG_LAST && !svcWr && !evt.internalReset)
      |=> chipReset && elapsed == 18'h0)
      else $error("long timeout missed");
   AST_NO_EARLY_FIRE: assert property (@(posedge clk) disable iff (sys_rst)
      (elapsed != lastCyc) |=> !chipReset)
      else $error("reset before the timeout");
   AST_RST_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
      chipReset |-> elapsed == 18'h0)
      else $error("count kept across overflow");

   // reset pin, enable output, event capture, control write and read data hold
   AST_PIN_ON_FIRE: assert property (@(posedge clk) disable iff (sys_rst)
      fire |=> rstPinOe && !rstPinOut)
      else $error("pin not driven low");
   AST_PIN_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
      (rstPinOe && pinCnt_r != 6'h0) |=> rstPinOe)
      else $error("pin released early");
   AST_ENABLE_OUT: assert property (@(posedge clk) disable iff (sys_rst)
      (mode.monitorMode && !mode.hiVoltRst && !mode.hiVoltIrq && !ctrl_r[0]) |=> wdEnable)
      else $error("enable missing without test voltage");
   AST_ENABLE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_r[0] |=> !wdEnable)
      else $error("enable shown while disabled");
   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> irq == |(iStat_r & $past(iEn_r)))
      else $error("event line wrong");
   AST_OVF_EVENT: assert property (@(posedge clk) disable iff (sys_rst)
      fire |=> iStat_r[0])
      else $error("overflow event lost");
   AST_SVC_EVENT: assert property (@(posedge clk) disable iff (sys_rst)
      svcWr |=> iStat_r[1])
      else $error("clear event lost");
   AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      ctrlWr |=> ctrl_r == $past(avs_writedata[1:0]))
      else $error("control write lost");
   AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data changed without a read");
endmodule
`default_nettype wire

// ==== wdt_tb.sv ====
// testbench: drives the watchdog over its register bus and core inputs and judges its outputs
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int unsigned SC  = 40;
   localparam int unsigned LC  = 100;
   localparam logic [7:0]  VEC = 8'h5a; // arbitrary value
   logic               clk, sysRst, avsRead, avsWrite, avsWait;
   logic               chipReset, rstPinOut, rstPinOe, wdEnable, irq;
   logic [15:0]        avsAddr;
   logic [31:0]        avsWdata, avsRdata, rd, sav;
   logic [4:0]         modes [4];
   wdt_pkg::wdt_mode_t mode;
   wdt_pkg::wdt_evt_t  evt;
   int                 errTotal, checksDone, fires, f;

   wdt_top #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC), .RESET_VEC_LO(VEC)) dut (
      .clk(clk), .sys_rst(sysRst), .avs_address(avsAddr), .avs_read(avsRead),
      .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(4'hf),
      .avs_readdata(avsRdata), .avs_waitrequest(avsWait), .mode(mode), .evt(evt),
      .chipReset(chipReset), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
      .wdEnable(wdEnable), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (chipReset === 1'b1) fires <= fires + 1;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errTotal++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one avalon access; waits for waitrequest low, takes read data at that edge
   // a stuck slave is ended by the bench watchdog only
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      avsAddr  <= a;
      avsRead  <= ~wr;
      avsWrite <= wr;
      avsWdata <= d;
      do begin
         @(posedge clk);
      end while (avsWait !== 1'b0);
      rd = avsRdata;
      avsRead  <= 1'b0;
      avsWrite <= 1'b0;
   endtask
   task automatic pulse(input logic [2:0] e);
      @(posedge clk);
      evt <= wdt_pkg::wdt_evt_t'(e);
      @(posedge clk);
      evt <= '0;
      @(posedge clk);
   endtask
   // total clear, then time the overflow and the pin drive after it
   task automatic tmo(input int lim);
      int n;
      int m;
      pulse(3'h1);
      n = 1;
      while (chipReset !== 1'b1 && n < 2 * lim) begin
         @(posedge clk);
         n++;
      end
      chk("timeout in range", 32'(n + 2 >= lim && n <= lim + 2), 32'h1);
      m = 0;
      while (rstPinOe === 1'b1 && m < 100) begin
         if (m == 1) chk("chipReset pulse", 32'(chipReset), 32'h0);
         chk("pin drives low", 32'(rstPinOut), 32'h0);
         m++;
         @(posedge clk);
      end
      chk("pin low cycles", 32'(m), 32'd32);
   endtask

   task automatic t_regs;
      bus(1'b1, wdt_pkg::IDX_CLEAR, 32'h0);
      bus(1'b0, wdt_pkg::IDX_CTRL, '0);
      chk("ctrl reset", rd, 32'h0);
      bus(1'b0, wdt_pkg::IDX_CLEAR, '0);
      chk("clear loc read", rd, {24'h0, VEC});
      bus(1'b0, 16'h0100, '0);
      chk("unmapped read", rd, 32'h0);
      chk("enable after reset", 32'(wdEnable), 32'h1);
      repeat (4200) @(posedge clk);
   endtask
   task automatic t_irq;
      bus(1'b1, wdt_pkg::IDX_CTRL, 32'h1);
      bus(1'b0, wdt_pkg::IDX_RSTAT, '0);
      chk("reset flag", 32'(rd[0]), 32'h1);
      bus(1'b1, wdt_pkg::IDX_RSTAT, 32'h1);
      bus(1'b0, wdt_pkg::IDX_RSTAT, '0);
      chk("reset flag cleared", 32'(rd[0]), 32'h0);
      bus(1'b1, wdt_pkg::IDX_IEN, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq raised", 32'(irq), 32'h1);
      bus(1'b1, wdt_pkg::IDX_IEN, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'(irq), 32'h0);
      bus(1'b1, wdt_pkg::IDX_IEN, 32'h3);
      bus(1'b1, wdt_pkg::IDX_ICLR, 32'h3);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'(irq), 32'h0);
   endtask
   task automatic t_clear;
      bus(1'b1, wdt_pkg::IDX_CTRL, 32'h0);
      pulse(3'h1);
      f = fires;
      repeat (6) begin
         repeat (SC / 2) @(posedge clk);
         bus(1'b1, wdt_pkg::IDX_CLEAR, 32'ha5);
      end
      chk("no fire while served", 32'(fires - f), 32'h0);
      bus(1'b0, wdt_pkg::IDX_ISTAT, '0);
      chk("clear event", 32'(rd[1]), 32'h1);
      chk("clear event irq", 32'(irq), 32'h1);
      bus(1'b1, wdt_pkg::IDX_ICLR, 32'h3);
   endtask
   task automatic t_block;
      modes = '{5'b00000, 5'b01010, 5'b01001, 5'b00110};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, wdt_pkg::IDX_CTRL, (i == 0) ? 32'h1 : 32'h0);
         mode <= wdt_pkg::wdt_mode_t'(modes[i]);
         pulse(3'h1);
         f = fires;
         repeat (LC + 10) @(posedge clk);
         chk("no fire when blocked", 32'(fires - f), 32'h0);
         chk("enable off", 32'(wdEnable), 32'h0);
      end
      mode <= wdt_pkg::wdt_mode_t'(5'b01000);
      repeat (3) @(posedge clk);
      chk("enable after irq pin", 32'(wdEnable), 32'h1);
   endtask
   task automatic t_freeze;
      bus(1'b1, wdt_pkg::IDX_CTRL, 32'h1);
      bus(1'b1, wdt_pkg::IDX_CLEAR, 32'h0);
      mode <= wdt_pkg::wdt_mode_t'(5'b10000);
      bus(1'b0, wdt_pkg::IDX_STATE, '0);
      sav = rd;
      repeat (20) @(posedge clk);
      bus(1'b0, wdt_pkg::IDX_STATE, '0);
      chk("frozen in stop", rd, sav);
      mode <= '0;
      for (int i = 0; i < 2; i++) begin
         repeat (30) @(posedge clk);
         pulse((i == 0) ? 3'h4 : 3'h2);
         bus(1'b0, wdt_pkg::IDX_STATE, '0);
         chk("prescaler cleared", 32'(rd[11:0] <= 12'h6), 32'h1);
      end
   endtask

   task automatic tallyAndFinish;
      $display("checks %0d errors %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errTotal++;
      $display("Error run expected finish seen timeout");
      tallyAndFinish();
   end
   initial begin
      sysRst = 1'b1;
      avsAddr = '0;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWdata = '0;
      mode = '0;
      evt = '0;
      errTotal = 0;
      checksDone = 0;
      repeat (5) @(posedge clk);
      sysRst <= 1'b0;
      t_regs();
      tmo(SC);
      t_irq();
      t_clear();
      bus(1'b1, wdt_pkg::IDX_CTRL, 32'h2);
      tmo(LC);
      t_block();
      t_freeze();
      tallyAndFinish();
   end
endmodule
`default_nettype wire
